/* File: core/channel_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module channel_sequencer (
	input  wire logic                 ref_clk_i,
	input  wire logic                 reset_n_i,
	input  wire seq_pkg::seq_config_t config_i,
	input  wire logic                 slot_write_i,
	input  wire logic [6:0]           slot_index_i,
	input  wire logic [3:0]           slot_channel_i,
	input  wire logic                 convert_start_i,
	input  wire logic [4:0]           host_channel_i,
	output var seq_pkg::conversion_t  conversion_o,
	output logic [6:0]                position_o
);
	////////////////////////////////////////////////////////////////////////////
	// State.
	seq_pkg::conversion_t conversion;
	seq_pkg::conversion_t next_conversion;
	logic [6:0]           slot_pos;
	logic [6:0]           next_slot_pos;
	logic                 temp_phase;
	logic                 next_temp_phase;
	logic [4:0]           std_pos;
	logic [4:0]           next_std_pos;
	logic [3:0]           slot_channel;
	seq_pkg::seq_mode_t   mode;
	logic [4:0]           std_pick;
	logic                 std_found;
	logic                 std_last;
	logic [7:0]           pass_count;
	logic [7:0]           next_pass_count;

	slot_table u_slot_table (
		.ref_clk_i      (ref_clk_i),
		.reset_n_i      (reset_n_i),
		.write_i        (slot_write_i),
		.write_index_i  (slot_index_i),
		.write_channel_i(slot_channel_i),
		.read_index_i   (slot_pos),
		.read_channel_o (slot_channel)
	);

	always_comb begin
		if (config_i.standard_sequencer_enable) begin
			mode = seq_pkg::SEQ_STANDARD;
		end else if (config_i.host_command_mode) begin
			mode = seq_pkg::SEQ_HOST;
		end else begin
			mode = seq_pkg::SEQ_SLOTS;
		end
	end

	// Find the next enabled standard channel at or after std_pos, wrapping once.
	always_comb begin
		std_pick  = 5'h00;
		std_found = 1'b0;
		for (int k = 0; k < 34; k++) begin
			if (!std_found) begin
				if (k < 17 && int'(std_pos) + k < 17 &&
				    config_i.standard_channel_enable[int'(std_pos) + k]) begin
					std_pick  = 5'(int'(std_pos) + k);
					std_found = 1'b1;
				end else if (k >= 17 && config_i.standard_channel_enable[k - 17]) begin
					std_pick  = 5'(k - 17);
					std_found = 1'b1;
				end
			end
		end
	end

	// The picked channel closes the pass when no enabled channel lies above it.
	always_comb begin
		std_last = 1'b1;
		for (int k = 0; k < 17; k++) begin
			if (k > int'(std_pick) && config_i.standard_channel_enable[k]) begin
				std_last = 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// At most one conversion per convert-start; none in standard mode with no channel enabled.
	always_comb begin
		next_conversion = '0;
		next_slot_pos   = slot_pos;
		next_temp_phase = temp_phase;
		next_std_pos    = std_pos;
		if (convert_start_i) begin
			next_conversion.valid = 1'b1;
			unique case (mode)
				seq_pkg::SEQ_STANDARD: begin
					next_conversion.valid    = std_found;
					next_conversion.channel  = std_pick;
					next_conversion.pass_end = std_last;
					next_std_pos = (std_pick == 5'd16) ? 5'h00 : 5'(std_pick + 5'd1);
				end
				seq_pkg::SEQ_HOST: begin
					next_conversion.channel  = host_channel_i;
					next_conversion.pass_end = 1'b1;
				end
				seq_pkg::SEQ_SLOTS: begin
					if (temp_phase) begin
						next_conversion.channel  = seq_pkg::TEMP_CHANNEL;
						next_conversion.pass_end = 1'b1;
						next_temp_phase = 1'b0;
						next_slot_pos   = 7'h00;
					end else begin
						next_conversion.channel = {1'b0, slot_channel};
						if (slot_pos >= config_i.last_slot_index) begin
							next_slot_pos = 7'h00;
							if (config_i.temperature_enable) begin
								next_temp_phase = 1'b1;
							end else begin
								next_conversion.pass_end = 1'b1;
							end
						end else begin
							next_slot_pos = slot_pos + 7'd1;
						end
					end
				end
				default: begin
					next_conversion.valid = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			conversion <= '0;
			slot_pos   <= 7'h00;
			temp_phase <= 1'b0;
			std_pos    <= 5'h00;
		end else begin
			conversion <= next_conversion;
			slot_pos   <= next_slot_pos;
			temp_phase <= next_temp_phase;
			std_pos    <= next_std_pos;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			position_o <= 7'h00;
		end else begin
			position_o <= next_slot_pos;
		end
	end

	assign conversion_o = conversion;

	////////////////////////////////////////////////////////////////////////////
	// Helper count of conversions within the current slot pass, for the checks only.
	always_comb begin
		next_pass_count = pass_count;
		if (mode != seq_pkg::SEQ_SLOTS) begin
			next_pass_count = 8'h00;
		end else if (conversion.valid) begin
			if (conversion.pass_end) begin
				next_pass_count = 8'h00;
			end else begin
				next_pass_count = 8'(pass_count + 8'd1);
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			pass_count <= 8'h00;
		end else begin
			pass_count <= next_pass_count;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);

	one_per_start_a: assert property (conversion.valid |-> $past(convert_start_i))
		else $error("conversion without convert start");
	slot_no_temp_a: assert property ($past(mode == seq_pkg::SEQ_SLOTS) && $past(!temp_phase)
		&& conversion.valid |-> conversion.channel < 5'd16)
		else $error("temperature taken from a slot");
	slot_bound_a: assert property (mode == seq_pkg::SEQ_SLOTS && $past(mode == seq_pkg::SEQ_SLOTS)
		&& $past(slot_pos) <= config_i.last_slot_index |-> slot_pos <= config_i.last_slot_index)
		else $error("slot beyond last index");
	wrap_zero_a: assert property (mode == seq_pkg::SEQ_SLOTS && convert_start_i && !temp_phase
		&& slot_pos == config_i.last_slot_index |=> slot_pos == 7'h00)
		else $error("no return to slot zero");
	temp_follow_a: assert property (mode == seq_pkg::SEQ_SLOTS && convert_start_i && temp_phase
		|=> conversion.channel == seq_pkg::TEMP_CHANNEL && conversion.pass_end)
		else $error("temperature slot missing");
	host_pass_a: assert property (mode == seq_pkg::SEQ_HOST && convert_start_i
		|=> conversion.channel == $past(host_channel_i))
		else $error("host channel not followed");
	std_enabled_a: assert property ($past(mode == seq_pkg::SEQ_STANDARD) && conversion.valid
		|-> config_i.standard_channel_enable[conversion.channel])
		else $error("disabled channel converted");
	slot_limit_a: assert property (mode == seq_pkg::SEQ_SLOTS && $past(mode == seq_pkg::SEQ_SLOTS)
		&& $past(convert_start_i) && !temp_phase
		|-> slot_pos <= $past(config_i.last_slot_index))
		else $error("slot index beyond programmed sequence");
	pass_length_a: assert property (mode == seq_pkg::SEQ_SLOTS && conversion.valid
		&& conversion.pass_end
		|-> pass_count == 8'(config_i.last_slot_index) + 8'(config_i.temperature_enable))
		else $error("slot pass length wrong");
	slot_pass_end_a: assert property ($past(mode == seq_pkg::SEQ_SLOTS) && conversion.valid
		&& conversion.pass_end
		|-> conversion.channel == seq_pkg::TEMP_CHANNEL || !$past(config_i.temperature_enable))
		else $error("slot pass ended before temperature");
	host_valid_a: assert property (mode == seq_pkg::SEQ_HOST && convert_start_i
		|=> conversion.valid)
		else $error("host request not converted");
	std_refuse_a: assert property (mode == seq_pkg::SEQ_STANDARD && convert_start_i
		&& config_i.standard_channel_enable == 17'h00000 |=> !conversion.valid)
		else $error("conversion with no channel enabled");

	temp_cov: cover property (conversion.valid && conversion.channel == seq_pkg::TEMP_CHANNEL);
	wrap_cov: cover property (conversion.valid && conversion.pass_end);
	host_cov: cover property (mode == seq_pkg::SEQ_HOST && conversion.valid);
	refuse_cov: cover property (mode == seq_pkg::SEQ_STANDARD && convert_start_i
		&& config_i.standard_channel_enable == 17'h00000);
	slot_pass_cov: cover property (mode == seq_pkg::SEQ_SLOTS && conversion.valid
		&& conversion.pass_end);
endmodule : channel_sequencer
`default_nettype wire

/* File: core/seq_pkg.sv */
package seq_pkg;

	localparam int unsigned NUM_SLOTS     = 128;
	localparam int unsigned SLOT_W        = 7;
	localparam int unsigned NUM_INPUTS    = 16;
	localparam int unsigned CHAN_W        = 5;
	localparam logic [4:0]  TEMP_CHANNEL  = 5'h10;
	localparam logic [6:0]  SLOT_RESET    = 7'h00;
	localparam logic [3:0]  INPUT_MASK    = 4'hf;
	localparam logic [16:0] STD_RESET     = 17'h00001;

	typedef enum logic [1:0] {
		MODE_IDLE    = 2'b00,
		MODE_CONVERT = 2'b01
	} run_state_t;

	typedef enum logic [1:0] {
		SEQ_STANDARD = 2'b00,
		SEQ_SLOTS    = 2'b01,
		SEQ_HOST     = 2'b11
	} seq_mode_t;

	typedef struct packed {
		logic       standard_sequencer_enable;
		logic       host_command_mode;
		logic [6:0] last_slot_index;
		logic       temperature_enable;
		logic [16:0] standard_channel_enable;
	} seq_config_t;

	typedef struct packed {
		logic       valid;
		logic [4:0] channel;
		logic       pass_end;
	} conversion_t;

endpackage : seq_pkg

/* File: core/slot_table.sv */
`timescale 1ns/1ps
`default_nettype none
module slot_table (
	input  wire logic                    ref_clk_i,
	input  wire logic                    reset_n_i,
	input  wire logic                    write_i,
	input  wire logic [seq_pkg::SLOT_W-1:0] write_index_i,
	input  wire logic [3:0]              write_channel_i,
	input  wire logic [seq_pkg::SLOT_W-1:0] read_index_i,
	output logic      [3:0]              read_channel_o
);
	logic [3:0] slot_channel_select [seq_pkg::NUM_SLOTS];
	logic [3:0] next_slot [seq_pkg::NUM_SLOTS];

	// Slots hold only 4-bit inputs, so the temperature code cannot be stored.
	generate
		for (genvar i = 0; i < seq_pkg::NUM_SLOTS; i++) begin : g_slot
			always_comb begin
				next_slot[i] = slot_channel_select[i];
				if (write_i && write_index_i == seq_pkg::SLOT_W'(i)) begin
					next_slot[i] = write_channel_i & seq_pkg::INPUT_MASK;
				end
			end
			always_ff @(posedge ref_clk_i) begin
				if (!reset_n_i) begin
					slot_channel_select[i] <= seq_pkg::SLOT_RESET[3:0];
				end else begin
					slot_channel_select[i] <= next_slot[i];
				end
			end
		end
	endgenerate

	assign read_channel_o = slot_channel_select[read_index_i];
endmodule : slot_table
`default_nettype wire

/* File: test/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input  wire logic            ref_clk_i,
	output var seq_pkg::seq_config_t config_o,
	output logic                 slot_write_o,
	output logic [6:0]           slot_index_o,
	output logic [3:0]           slot_channel_o,
	output logic                 convert_start_o,
	output logic [4:0]           host_channel_o
);
	// Three groups of three high-rate inputs, the first two closed by one low-rate input each; temperature closes the pass.
	logic [3:0] two_rate_list [11] = '{4'h5, 4'h9, 4'he, 4'h2, 4'h5, 4'h9, 4'he, 4'ha, 4'h5, 4'h9, 4'he};

	initial begin
		config_o = '0;
		slot_write_o = 1'b0;
		slot_index_o = 7'h00;
		slot_channel_o = 4'h0;
		convert_start_o = 1'b0;
		host_channel_o = 5'h00;
	end

	task automatic set_cfg(input seq_pkg::seq_config_t c);
		@(posedge ref_clk_i) config_o <= c;
	endtask : set_cfg

	task automatic program_two_rate;
		for (int i = 0; i < 11; i++) begin
			@(posedge ref_clk_i);
			slot_write_o <= 1'b1;
			slot_index_o <= 7'(i);
			slot_channel_o <= two_rate_list[i];
			@(posedge ref_clk_i) slot_write_o <= 1'b0;
		end
		set_cfg({1'b0, 1'b0, 7'h0a, 1'b1, 17'h00000});
	endtask : program_two_rate

	task automatic start(input logic v);
		@(posedge ref_clk_i) convert_start_o <= v;
	endtask : start

	task automatic pulse(input logic [4:0] ch);
		@(posedge ref_clk_i);
		host_channel_o <= ch;
		convert_start_o <= 1'b1;
		@(posedge ref_clk_i) convert_start_o <= 1'b0;
	endtask : pulse
endmodule : host_model
`default_nettype wire

/* File: test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic                 ref_clk_i;
	logic                 reset_n_i;
	seq_pkg::seq_config_t cfg;
	logic                 wr;
	logic [6:0]           idx;
	logic [3:0]           sch;
	logic                 start;
	logic [4:0]           hch;
	seq_pkg::conversion_t conversion;
	logic [6:0]           position;
	int                   err_total;
	int                   check_count;
	logic [6:0]           exp_q [$];

	host_model host (.ref_clk_i(ref_clk_i), .config_o(cfg), .slot_write_o(wr), .slot_index_o(idx),
		.slot_channel_o(sch), .convert_start_o(start), .host_channel_o(hch));
	channel_sequencer dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .config_i(cfg),
		.slot_write_i(wr), .slot_index_i(idx), .slot_channel_i(sch), .convert_start_i(start),
		.host_channel_i(hch), .conversion_o(conversion), .position_o(position));

	initial begin
		ref_clk_i = 1'b0;
		forever #50 ref_clk_i = ~ref_clk_i;
	end

	task automatic check(input logic [6:0] seen, input logic [6:0] exp, input string what);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic end_of_test;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_of_test

	task automatic do_reset;
		@(posedge ref_clk_i) reset_n_i <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
	endtask : do_reset

	// Back-to-back starts, one result checked per cycle against the expected list.
	task automatic burst(input int n);
		host.start(1'b1);
		for (int i = 0; i < n; i++) begin
			if (i == n - 1) host.start(1'b0);
			else @(posedge ref_clk_i);
			@(negedge ref_clk_i) check(conversion, exp_q[i % exp_q.size()], "conversion");
		end
	endtask : burst

	task automatic standard_pass;
		do_reset();
		host.set_cfg({1'b1, 1'b0, 7'h00, 1'b0, 17'h10009});
		exp_q = '{7'h40, 7'h46, 7'h61};
		burst(6);
	endtask : standard_pass

	task automatic none_enabled;
		do_reset();
		host.set_cfg({1'b1, 1'b0, 7'h00, 1'b0, 17'h00000});
		host.pulse(5'h00);
		@(negedge ref_clk_i) check({6'h00, conversion.valid}, 7'h00, "refused valid");
	endtask : none_enabled

	task automatic two_rate;
		do_reset();
		host.program_two_rate();
		exp_q = {};
		foreach (host.two_rate_list[i]) exp_q.push_back({2'b10, host.two_rate_list[i], 1'b0});
		exp_q.push_back({1'b1, seq_pkg::TEMP_CHANNEL, 1'b1});
		burst(24);
		check(position, 7'h00, "position after two passes");
	endtask : two_rate

	task automatic host_mode;
		do_reset();
		host.set_cfg({1'b0, 1'b1, 7'h00, 1'b0, 17'h00000});
		for (int i = 0; i < 20; i++) begin
			host.pulse(5'(i % 17));
			@(negedge ref_clk_i) check({1'b0, conversion.valid, conversion.channel}, {2'b01, 5'(i % 17)}, "host channel");
		end
	endtask : host_mode

	initial begin
		reset_n_i = 1'b0;
		err_total = 0;
		check_count = 0;
		standard_pass();
		none_enabled();
		two_rate();
		host_mode();
		end_of_test();
	end

	initial begin
		#500000;
		err_total++;
		end_of_test();
	end
endmodule : tb
`default_nettype wire
